/* File: hdl/sbc_controller.sv */
// Sensorless three-phase commutation controller with APB control registers.
// Assumes external comparators deliver the position and timer levels as pins.
`timescale 1ns/10ps
`default_nettype none
module sbc_controller
  import sbc_pkg::*;
#(
  parameter int FORCED_HI = FORCED_HI_CYCLES,
  parameter int FORCED_MID = FORCED_MID_CYCLES,
  parameter int FORCED_LOW = FORCED_LOW_CYCLES,
  parameter int RESTART_WAIT = RESTART_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic transistor_polarity_select,
  input wire logic overlap_mode_select,
  input wire logic top_commutation_limit_select,
  input wire logic [1:0] startup_rate_select,
  input wire logic advance_angle_select,
  input wire logic direction_select,
  input wire logic overcurrent_sense,
  input wire logic position_sense,
  input wire logic excitation_timer_node,
  output logic phase_u_high_drive,
  output logic phase_u_low_drive,
  output logic phase_v_high_drive,
  output logic phase_v_low_drive,
  output logic phase_w_high_drive,
  output logic phase_w_low_drive,
  output logic duty_monitor,
  output logic ramp_discharge,
  output logic rotation_pulse_output
);
  logic [9:0] pin_raw;
  logic [9:0] pin_meta;
  logic [9:0] pin_sync;
  logic pol_sel, ovl_sel, lim_sel, lead_sel, dir_sel, oc, pos_in, timer_high;
  logic [1:0] fst_sel;
  logic [7:0] speed_cmd;
  logic [15:0] ramp_up_rate;
  logic [15:0] ramp_down_rate;
  logic [7:0] fault_count;
  logic [31:0] status_word;
  logic [31:0] next_prdata;
  logic addr_ok, wr_en;
  sbc_state_type state, next_state;
  logic [2:0] state_code;
  logic [5:0] target_duty, ramp_level;
  logic [13:0] scaled;
  logic stop_cmd;
  logic [15:0] ramp_cnt;
  logic [7:0] pwm_cnt;
  logic pwm_on, pwm_on_q, pwm_fall;
  logic pos_sample, bemf_edge;
  logic [19:0] since_edge, last_interval, forced_step, fast_limit;
  logic [19:0] step_timer, delay_cnt, overlap_cnt;
  logic pending;
  logic [1:0] good_edges;
  logic [2:0] step, prev_step;
  logic [27:0] restart_cnt;
  logic too_fast, too_slow, nat_ready, restart_done, forced_tick, advance;
  logic drive_active, overlap_on;
  logic [5:0] cur_pat, prev_pat;
  logic [2:0] hs_on, ls_on, high_q, low_q;

  // Every mode and sense pin crosses two flops before any logic looks at it
  assign pin_raw = {excitation_timer_node, position_sense, overcurrent_sense, direction_select,
                    advance_angle_select, startup_rate_select, top_commutation_limit_select,
                    overlap_mode_select, transistor_polarity_select};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta <= 10'h000;
      pin_sync <= 10'h000;
    end else begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
    end
  end
  assign pol_sel = pin_sync[0];
  assign ovl_sel = pin_sync[1];
  assign lim_sel = pin_sync[2];
  assign fst_sel = pin_sync[4:3];
  assign lead_sel = pin_sync[5];
  assign dir_sel = pin_sync[6];
  assign oc = pin_sync[7];
  assign pos_in = pin_sync[8];
  assign timer_high = pin_sync[9];

  // APB slave: zero wait states, read data captured in the setup cycle
  assign addr_ok = (paddr == ADDR_SPEED) || (paddr == ADDR_RAMP) || (paddr == ADDR_STATUS);
  assign pready = psel & penable;
  assign pslverr = psel & penable & ~addr_ok;
  assign wr_en = psel & penable & pwrite;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      speed_cmd <= SPEED_RST;
      ramp_up_rate <= RAMP_UP_RST;
      ramp_down_rate <= RAMP_DOWN_RST;
    end else if (wr_en && paddr == ADDR_SPEED) begin
      if (pstrb[0]) speed_cmd <= pwdata[7:0];
    end else if (wr_en && paddr == ADDR_RAMP) begin
      if (pstrb[0]) ramp_up_rate[7:0] <= pwdata[RAMP_UP_LSB +: 8];
      if (pstrb[1]) ramp_up_rate[15:8] <= pwdata[RAMP_UP_LSB + 8 +: 8];
      if (pstrb[2]) ramp_down_rate[7:0] <= pwdata[RAMP_DOWN_LSB +: 8];
      if (pstrb[3]) ramp_down_rate[15:8] <= pwdata[RAMP_DOWN_LSB + 8 +: 8];
    end
  end
  always_comb begin
    case (state)
      st_stop: state_code = 3'h0;
      st_align: state_code = 3'h1;
      st_forced: state_code = 3'h2;
      st_natural: state_code = 3'h3;
      st_fault: state_code = 3'h4;
      default: state_code = 3'h0;
    endcase
    status_word = 32'h00000000;
    status_word[ST_STATE_LSB +: 3] = state_code;
    status_word[ST_STEP_LSB +: 3] = step;
    status_word[ST_RAMP_LSB +: 6] = ramp_level;
    status_word[ST_TARGET_LSB +: 6] = target_duty;
    status_word[ST_OC_BIT] = oc;
    status_word[ST_POS_BIT] = pos_sample;
    status_word[ST_FAULTS_LSB +: 8] = fault_count;
    case (paddr)
      ADDR_SPEED: next_prdata = {24'h000000, speed_cmd};
      ADDR_RAMP: next_prdata = {ramp_down_rate, ramp_up_rate};
      ADDR_STATUS: next_prdata = status_word;
      default: next_prdata = 32'h00000000;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h00000000;
    else if (psel && !penable) prdata <= next_prdata;
  end

  // Speed command conversion; the divide by a constant costs area but no latency
  assign scaled = ({6'h00, speed_cmd - AD_LOW} * DUTY_STEPS) / AD_SPAN;
  always_comb begin
    if (speed_cmd < AD_LOW) target_duty = 6'h00;
    else if (speed_cmd >= AD_HIGH) target_duty = DUTY_MAX;
    else target_duty = scaled[5:0] + 6'h01;
  end
  assign stop_cmd = (target_duty == 6'h00);

  // Ramp level stands in for the soft-start capacitor
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ramp_level <= 6'h00;
      ramp_cnt <= 16'h0000;
      ramp_discharge <= 1'b0;
    end else begin
      ramp_discharge <= stop_cmd;
      if (stop_cmd) begin
        ramp_level <= 6'h00;
        ramp_cnt <= 16'h0000;
      end else if (ramp_level == target_duty) begin
        ramp_cnt <= 16'h0000;
      end else if (ramp_cnt >= ((ramp_level < target_duty) ? ramp_up_rate : ramp_down_rate)) begin
        ramp_cnt <= 16'h0000;
        if (ramp_level < target_duty) ramp_level <= ramp_level + 6'h01;
        else ramp_level <= ramp_level - 6'h01;
      end else begin
        ramp_cnt <= ramp_cnt + 16'h0001;
      end
    end
  end

  // PWM carrier wraps every 256 cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_cnt <= 8'h00;
      pwm_on_q <= 1'b0;
    end else begin
      pwm_cnt <= pwm_cnt + 8'h01;
      pwm_on_q <= pwm_on;
    end
  end
  assign pwm_on = (pwm_cnt < {ramp_level, 2'b00});
  assign pwm_fall = pwm_on_q & ~pwm_on;

  // Position sampled at the PWM falling edge only, away from switching noise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_sample <= 1'b0;
      bemf_edge <= 1'b0;
    end else begin
      bemf_edge <= pwm_fall & (pos_in != pos_sample);
      if (pwm_fall) pos_sample <= pos_in;
    end
  end

  always_comb begin
    case (fst_sel)
      FST_HIGH: forced_step = 20'(FORCED_HI);
      FST_MID: forced_step = 20'(FORCED_MID);
      default: forced_step = 20'(FORCED_LOW);
    endcase
    if (fst_sel == FST_HIGH) fast_limit = LIMIT_FAST;
    else if (lim_sel) fast_limit = LIMIT_SLOW_HI;
    else fast_limit = LIMIT_SLOW_LO;
  end
  assign too_fast = bemf_edge & (since_edge < fast_limit);
  assign too_slow = (since_edge >= forced_step);
  assign nat_ready = bemf_edge & (since_edge < forced_step) & (good_edges == NAT_EDGES - 2'h1);
  assign restart_done = (restart_cnt == 28'(RESTART_WAIT - 1));
  // Compare with >= so a shorter step chosen mid-run cannot strand the timer past its end
  assign forced_tick = (step_timer >= forced_step - 20'h00001);

  always_comb begin
    case (state)
      st_stop: next_state = stop_cmd ? st_stop : st_align;
      st_align: begin
        if (stop_cmd) next_state = st_stop;
        else if (!timer_high) next_state = st_forced;
        else next_state = st_align;
      end
      st_forced: begin
        if (stop_cmd) next_state = st_stop;
        else if (nat_ready) next_state = st_natural;
        else next_state = st_forced;
      end
      st_natural: begin
        if (stop_cmd) next_state = st_stop;
        else if (too_fast || too_slow) next_state = st_fault;
        else next_state = st_natural;
      end
      st_fault: begin
        if (stop_cmd) next_state = st_stop;
        else if (restart_done) next_state = st_align;
        else next_state = st_fault;
      end
      default: next_state = st_stop;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) state <= st_stop;
    else state <= next_state;
  end

  // Restart delay and fault tally
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      restart_cnt <= 28'h0000000;
      fault_count <= 8'h00;
    end else begin
      if (state == st_fault && !restart_done) restart_cnt <= restart_cnt + 28'h0000001;
      else restart_cnt <= 28'h0000000;
      if (state == st_natural && next_state == st_fault) fault_count <= fault_count + 8'h01;
    end
  end

  // Edge interval measurement, saturating so a stalled rotor still reads as slow
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      since_edge <= 20'h00000;
      last_interval <= 20'h00000;
      good_edges <= 2'h0;
    end else if (state != st_forced && state != st_natural) begin
      since_edge <= 20'h00000;
      last_interval <= 20'h00000;
      good_edges <= 2'h0;
    end else if (bemf_edge) begin
      since_edge <= 20'h00000;
      last_interval <= since_edge;
      if (since_edge < forced_step && good_edges != NAT_EDGES) good_edges <= good_edges + 2'h1;
      else if (since_edge >= forced_step) good_edges <= 2'h0;
    end else if (since_edge != 20'hfffff) begin
      since_edge <= since_edge + 20'h00001;
    end
  end

  // Step sequencing: forced timer, or back-EMF edge plus lead-adjusted delay
  assign advance = (state == st_forced && forced_tick) || (state == st_natural && pending &&
                   delay_cnt == 20'h00000);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_timer <= 20'h00000;
      delay_cnt <= 20'h00000;
      pending <= 1'b0;
    end else begin
      if (state == st_forced && !forced_tick) step_timer <= step_timer + 20'h00001;
      else step_timer <= 20'h00000;
      if (state == st_natural && bemf_edge) begin
        pending <= 1'b1;
        if (lead_sel) delay_cnt <= since_edge >> 2;
        else delay_cnt <= (since_edge >> 2) + (since_edge >> 3);
      end else if (state != st_natural || advance) begin
        pending <= 1'b0;
        delay_cnt <= 20'h00000;
      end else if (delay_cnt != 20'h00000) begin
        delay_cnt <= delay_cnt - 20'h00001;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step <= 3'h0;
      prev_step <= 3'h0;
      overlap_cnt <= 20'h00000;
    end else if (state == st_stop || state == st_align || state == st_fault) begin
      step <= 3'h0;
      prev_step <= 3'h0;
      overlap_cnt <= 20'h00000;
    end else if (advance) begin
      prev_step <= step;
      if (dir_sel) step <= (step == 3'h0) ? 3'h5 : step - 3'h1;
      else step <= (step == 3'h5) ? 3'h0 : step + 3'h1;
      if (state == st_forced) overlap_cnt <= forced_step >> 3;
      else if (lead_sel) overlap_cnt <= last_interval >> 2;
      else overlap_cnt <= last_interval >> 3;
    end else if (overlap_cnt != 20'h00000) begin
      overlap_cnt <= overlap_cnt - 20'h00001;
    end
  end

  // Pattern is {high side W V U, low side W V U}
  function automatic logic [5:0] sbc_pattern(input logic [2:0] s);
    case (s)
      3'h0: sbc_pattern = 6'b001_010;
      3'h1: sbc_pattern = 6'b001_100;
      3'h2: sbc_pattern = 6'b010_100;
      3'h3: sbc_pattern = 6'b010_001;
      3'h4: sbc_pattern = 6'b100_001;
      3'h5: sbc_pattern = 6'b100_010;
      default: sbc_pattern = 6'b000_000;
    endcase
  endfunction
  assign cur_pat = sbc_pattern(step);
  assign prev_pat = sbc_pattern(prev_step);
  assign overlap_on = ~ovl_sel & (overlap_cnt != 20'h00000);
  assign drive_active = (state == st_align || state == st_forced || state == st_natural) &
                        ~oc & ~stop_cmd;
  always_comb begin
    if (!drive_active) begin
      hs_on = 3'b000;
      ls_on = 3'b000;
    end else if (overlap_on) begin
      hs_on = (cur_pat[5:3] | prev_pat[5:3]) & {3{pwm_on}};
      ls_on = cur_pat[2:0] | prev_pat[2:0];
    end else begin
      hs_on = cur_pat[5:3] & {3{pwm_on}};
      ls_on = cur_pat[2:0];
    end
  end

  generate
    for (genvar i = 0; i < 3; i++) begin : g_phase
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          high_q[i] <= 1'b0;
          low_q[i] <= 1'b0;
        end else begin
          high_q[i] <= pol_sel ? ~hs_on[i] : hs_on[i];
          low_q[i] <= ls_on[i];
        end
      end
    end
  endgenerate
  assign phase_u_high_drive = high_q[0];
  assign phase_v_high_drive = high_q[1];
  assign phase_w_high_drive = high_q[2];
  assign phase_u_low_drive = low_q[0];
  assign phase_v_low_drive = low_q[1];
  assign phase_w_low_drive = low_q[2];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      duty_monitor <= 1'b0;
      rotation_pulse_output <= 1'b0;
    end else begin
      duty_monitor <= pwm_on & ~oc;
      if (state != st_natural) rotation_pulse_output <= 1'b0;
      else if (bemf_edge) rotation_pulse_output <= ~rotation_pulse_output;
    end
  end
endmodule
`default_nettype wire

/* File: hdl/sbc_pkg.sv */
// Constants for the sensorless brushless commutation controller.
// Assumes a single 200 MHz pclk domain and a 32-bit APB register port.
package sbc_pkg;
  // APB register byte addresses
  localparam logic [11:0] ADDR_SPEED = 12'h000;
  localparam logic [11:0] ADDR_RAMP = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;
  // Reset values
  localparam logic [7:0] SPEED_RST = 8'h00;
  localparam logic [15:0] RAMP_UP_RST = 16'h4000;
  localparam logic [15:0] RAMP_DOWN_RST = 16'h0700;
  // Field positions
  localparam int RAMP_UP_LSB = 0;
  localparam int RAMP_DOWN_LSB = 16;
  localparam int ST_STATE_LSB = 0;
  localparam int ST_STEP_LSB = 3;
  localparam int ST_RAMP_LSB = 6;
  localparam int ST_TARGET_LSB = 12;
  localparam int ST_OC_BIT = 18;
  localparam int ST_POS_BIT = 19;
  localparam int ST_FAULTS_LSB = 20;
  // Speed command scale: 8'hff is full supply
  localparam logic [7:0] AD_LOW = 8'h33;
  localparam logic [7:0] AD_HIGH = 8'hcc;
  localparam logic [13:0] AD_SPAN = 14'h0099;
  localparam logic [13:0] DUTY_STEPS = 14'h003e;
  localparam logic [5:0] DUTY_MAX = 6'h3f;
  // Commutation timing, in pclk cycles per commutation step
  localparam int FORCED_HI_CYCLES = 65536;
  localparam int FORCED_MID_CYCLES = 131072;
  localparam int FORCED_LOW_CYCLES = 262144;
  localparam logic [19:0] LIMIT_SLOW_HI = 20'h00800;
  localparam logic [19:0] LIMIT_SLOW_LO = 20'h01000;
  localparam logic [19:0] LIMIT_FAST = 20'h00100;
  localparam logic [1:0] NAT_EDGES = 2'h2;
  // Restart delay after a fault
  localparam int RESTART_TIME_MS = 1000;
  localparam int CLK_KHZ = 200000;
  localparam int RESTART_CYCLES = RESTART_TIME_MS * CLK_KHZ;
  // Startup rate select pin encoding
  localparam logic [1:0] FST_HIGH = 2'h3;
  localparam logic [1:0] FST_MID = 2'h1;
  typedef enum logic [2:0] {st_stop, st_align, st_forced, st_natural, st_fault} sbc_state_type;
endpackage

/* File: verif/sbc_chk.sv */
// Pin-level assertions for the commutation controller.
// Assumes a bind to sbc_controller; sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module sbc_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic transistor_polarity_select,
  input wire logic overcurrent_sense,
  input wire logic phase_u_high_drive,
  input wire logic phase_u_low_drive,
  input wire logic phase_v_high_drive,
  input wire logic phase_v_low_drive,
  input wire logic phase_w_high_drive,
  input wire logic phase_w_low_drive,
  input wire logic duty_monitor,
  input wire logic ramp_discharge,
  input wire logic rotation_pulse_output
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic [2:0] lows = {phase_u_low_drive, phase_v_low_drive, phase_w_low_drive};
  wire logic [2:0] highs = {phase_u_high_drive, phase_v_high_drive, phase_w_high_drive};
  // Four samples cover the two sync stages plus the output register
  property p_oc_low;
    overcurrent_sense [*4] |-> lows == 3'h0;
  endproperty
  a_oc_low: assert property (p_oc_low) else $error("low drive on in overcurrent");
  property p_oc_duty;
    overcurrent_sense [*4] |-> !duty_monitor;
  endproperty
  a_oc_duty: assert property (p_oc_duty) else $error("monitor high in overcurrent");
  property p_oc_hi_p;
    (overcurrent_sense && transistor_polarity_select) [*4] |-> highs == 3'h7;
  endproperty
  a_oc_hi_p: assert property (p_oc_hi_p) else $error("high drive not idle high");
  property p_oc_hi_n;
    (overcurrent_sense && !transistor_polarity_select) [*4] |-> highs == 3'h0;
  endproperty
  a_oc_hi_n: assert property (p_oc_hi_n) else $error("high drive not idle low");
  // A phase never has both its transistors on
  property p_no_shoot;
    $stable(transistor_polarity_select) [*4] |->
      (lows & (highs ^ {3{transistor_polarity_select}})) == 3'h0;
  endproperty
  a_no_shoot: assert property (p_no_shoot) else $error("phase shoot through");
  property p_stop_low;
    ramp_discharge [*3] |-> lows == 3'h0 && !duty_monitor;
  endproperty
  a_stop_low: assert property (p_stop_low) else $error("drive active while stopped");
  property p_stop_high;
    (ramp_discharge && $stable(transistor_polarity_select)) [*4] |->
      highs == {3{transistor_polarity_select}};
  endproperty
  a_stop_high: assert property (p_stop_high) else $error("high drive active stopped");
  property p_stop_pulse;
    ramp_discharge [*3] |-> !rotation_pulse_output;
  endproperty
  a_stop_pulse: assert property (p_stop_pulse) else $error("pulse while stopped");
endmodule
`default_nettype wire

/* File: verif/sbc_motor.sv */
// Behavioural motor and sensing network beyond the gate pins.
// Assumes the low-side drives show whether the bridge is energised.
`timescale 1ns/10ps
`default_nettype none
module sbc_motor #(
  parameter int ALIGN = 300,
  parameter int HALF = 768
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic spin,
  input wire logic phase_u_low_drive,
  input wire logic phase_v_low_drive,
  input wire logic phase_w_low_drive,
  output logic position_sense,
  output logic excitation_timer_node
);
  int align_cnt;
  int half_cnt;
  // Timer node recharges while the bridge idles, so each restart aligns again
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      align_cnt <= 0;
    end else if (!(phase_u_low_drive || phase_v_low_drive || phase_w_low_drive)) begin
      align_cnt <= 0;
    end else if (align_cnt < ALIGN) begin
      align_cnt <= align_cnt + 1;
    end
  end
  assign excitation_timer_node = align_cnt < ALIGN;
  // A stalled rotor leaves the majority level steady
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_cnt <= 0;
      position_sense <= 1'b0;
    end else if (spin) begin
      half_cnt <= (half_cnt == HALF - 1) ? 0 : half_cnt + 1;
      if (half_cnt == HALF - 1) begin
        position_sense <= !position_sense;
      end
    end
  end
endmodule
`default_nettype wire

/* File: verif/testbench.sv */
// Self-checking bench for the commutation controller.
// Assumes the motor model answers on the position and timer pins.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import sbc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, perr, p0;
  logic pol, lap, lim, adv, dir, oc, spin, pos, tmr, rot, duty, disch;
  logic [3:0] strb;
  logic uh, ul, vh, vl, wh, wl;
  logic [1:0] rate;
  logic [2:0] s0, lows, highs;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  int n_mismatch, n_tests, n_cyc, n_pair, n_on;
  logic [7:0] cmd [8] = '{8'h33, 8'h34, 8'h80, 8'hcb, 8'hcc, 8'hff, 8'h00, 8'h32};
  logic [5:0] tgt [8] = '{6'h01, 6'h01, 6'h20, 6'h3e, 6'h3f, 6'h3f, 6'h00, 6'h00};
  int per [3] = '{2048, 4096, 8192};
  logic [1:0] rs [3] = '{2'h3, 2'h1, 2'h0};
  assign lows = {ul, vl, wl};
  assign highs = {uh, vh, wh};
  // Short forced steps keep the run brief; fast limits stay as built
  sbc_controller #(.FORCED_HI(2048), .FORCED_MID(4096), .FORCED_LOW(8192),
    .RESTART_WAIT(1000)) uut (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb(strb), .prdata,
    .pready, .pslverr, .transistor_polarity_select(pol), .overlap_mode_select(lap),
    .top_commutation_limit_select(lim), .startup_rate_select(rate),
    .advance_angle_select(adv), .direction_select(dir), .overcurrent_sense(oc),
    .position_sense(pos), .excitation_timer_node(tmr), .phase_u_high_drive(uh),
    .phase_u_low_drive(ul), .phase_v_high_drive(vh), .phase_v_low_drive(vl),
    .phase_w_high_drive(wh), .phase_w_low_drive(wl), .duty_monitor(duty),
    .ramp_discharge(disch), .rotation_pulse_output(rot));
  sbc_motor #(.ALIGN(300), .HALF(768)) u_motor (.pclk, .presetn, .spin,
    .phase_u_low_drive(ul), .phase_v_low_drive(vl), .phase_w_low_drive(wl),
    .position_sense(pos), .excitation_timer_node(tmr));
  task automatic test_done();
    if (n_mismatch == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic st();
    repeat (2) @(posedge pclk);
    apb(1'b0, ADDR_STATUS, 32'h0);
  endtask
  task automatic wait_st(input sbc_state_type s, input int n);
    st();
    for (int i = 0; i < n && q[2:0] !== s; i++) st();
  endtask
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // Hang guard; also counts cycles with two low sides on together
  always @(posedge pclk) begin
    n_cyc++;
    if ($countones(lows) > 1) n_pair++;
    if (n_cyc == 100000) begin
      n_mismatch++;
      test_done();
    end
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
    {strb, pol, lap, lim, rate, adv, dir, oc, spin} = 13'h1ff0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, ADDR_SPEED, 32'h0);
    chk("speed", q, SPEED_RST);
    apb(1'b0, ADDR_RAMP, 32'h0);
    chk("ramp", q, {RAMP_DOWN_RST, RAMP_UP_RST});
    apb(1'b1, 12'h00c, 32'hff);
    chk("unmapped", perr, 1);
    st();
    chk("state", q[2:0], st_stop);
    strb <= 4'h3;
    apb(1'b1, ADDR_RAMP, 32'h0);
    apb(1'b0, ADDR_RAMP, 32'h0);
    chk("ramp lanes", q, {RAMP_DOWN_RST, 16'h0000});
    strb <= 4'hf;
    foreach (cmd[i]) begin
      apb(1'b1, ADDR_SPEED, 32'(cmd[i]));
      st();
      chk("target", q[17:12], tgt[i]);
    end
    chk("discharge", disch, 1);
    chk("ramp level", q[11:6], 0);
    apb(1'b1, ADDR_SPEED, 32'hcc);
    wait_st(st_align, 20);
    chk("state", q[2:0], st_align);
    chk("lows", lows, 3'b010);
    repeat (100) @(posedge pclk);
    st();
    chk("ramp level", q[11:6], 63);
    repeat (256) begin
      @(posedge pclk);
      if (duty === 1'b1) n_on++;
    end
    chk("duty", n_on, 252);
    wait_st(st_forced, 100);
    chk("state", q[2:0], st_forced);
    for (int i = 0; i < 3; i++) begin
      rate <= rs[i];
      repeat (per[i] + 16) @(posedge pclk);
      st();
      s0 = q[5:3];
      repeat (per[i] - 5) @(posedge pclk);
      st();
      chk("step", q[5:3], (s0 + 1) % 6);
    end
    chk("overlap", n_pair, 0);
    {rate, dir, lap} <= 4'he;
    repeat (8300) @(posedge pclk);
    st();
    s0 = q[5:3];
    repeat (2043) @(posedge pclk);
    st();
    chk("step", q[5:3], (s0 + 5) % 6);
    chk("overlap", n_pair != 0, 1);
    {dir, adv, spin} <= 3'b011;
    wait_st(st_natural, 3000);
    chk("state", q[2:0], st_natural);
    p0 = rot;
    for (int i = 0; i < 3000 && rot === p0; i++) @(posedge pclk);
    chk("pulse", rot !== p0, 1);
    {oc, pol} <= 2'b10;
    repeat (8) @(posedge pclk);
    chk("highs", highs, 0);
    chk("lows", lows, 0);
    chk("duty", duty, 0);
    pol <= 1'b1;
    repeat (8) @(posedge pclk);
    chk("highs", highs, 3'h7);
    oc <= 1'b0;
    spin <= 1'b0;
    wait_st(st_fault, 2000);
    chk("state", q[2:0], st_fault);
    chk("lows", lows, 0);
    wait_st(st_align, 500);
    chk("state", q[2:0], st_align);
    chk("faults", q[27:20], 1);
    apb(1'b1, ADDR_SPEED, 32'h0);
    wait_st(st_stop, 10);
    chk("state", q[2:0], st_stop);
    // Middle rate with the limit pin low: edges every 768 cycles count as too fast
    {lim, rate, spin} <= 4'b0011;
    apb(1'b1, ADDR_SPEED, 32'hcc);
    wait_st(st_fault, 1500);
    chk("state", q[2:0], st_fault);
    chk("faults", q[27:20], 2);
    test_done();
  end
endmodule
bind sbc_controller sbc_chk u_chk (.pclk, .presetn, .transistor_polarity_select,
  .overcurrent_sense, .phase_u_high_drive, .phase_u_low_drive, .phase_v_high_drive,
  .phase_v_low_drive, .phase_w_high_drive, .phase_w_low_drive, .duty_monitor,
  .ramp_discharge, .rotation_pulse_output);
`default_nettype wire
